// [shared/udmab_pkg.sv]
package udmab_pkg;

	localparam int CLK_NS     = 10;
	localparam int MODES      = 6;
	localparam int DATA_W     = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_LW    = 4;
	localparam int TMR_W      = 8;
	localparam int MODE_W     = 3;
	localparam logic [MODE_W-1:0] MODE_MAX = 3'h5;

	// Words the recipient must still take after dropping ready
	localparam int EXTRA_WORDS = 3;
	localparam logic [FIFO_LW-1:0] RX_STOP_LVL =
		FIFO_LW'(FIFO_DEPTH - EXTRA_WORDS - 1);

	// Burst timing in nanoseconds, per mode for the arrays and one value for all modes otherwise
	localparam int T2CYC_NS [MODES] = '{230, 153, 115, 86, 57, 38};
	localparam int T_FS_NS  [MODES] = '{230, 200, 170, 130, 120, 90};
	localparam int T_LI_NS  [MODES] = '{150, 150, 150, 100, 100, 75};
	localparam int T_ENVX_NS[MODES] = '{70, 70, 70, 55, 55, 50};
	localparam int T_RFS_NS [MODES] = '{75, 70, 60, 60, 60, 50};
	localparam int T_RP_NS  [MODES] = '{160, 125, 100, 100, 100, 85};
	localparam int T_ENV_NS    = 20;
	localparam int T_MLI_NS    = 20;
	localparam int T_UI_NS     = 0;
	localparam int T_AZ_NS     = 10;
	localparam int T_ZAH_NS    = 20;
	localparam int T_ZAD_NS    = 0;
	localparam int T_IORDYZ_NS = 20;
	localparam int T_ZIORDY_NS = 0;
	localparam int T_ACK_NS    = 20;
	localparam int T_SS_NS     = 50;

	localparam logic [DATA_W-1:0] CRC_SEED = 16'h4ABA;
	localparam logic [DATA_W-1:0] CRC_POLY = 16'h1021;

	// Least times round up, never below one cycle
	function automatic logic [TMR_W-1:0] cyc_min(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		if (c < 1) c = 1;
		return TMR_W'(c);
	endfunction

	function automatic logic [DATA_W-1:0] crc_next(
		input logic [DATA_W-1:0] crc,
		input logic [DATA_W-1:0] word);
		logic [DATA_W-1:0] c;
		c = crc;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			if (c[DATA_W-1] ^ word[i]) c = (c << 1) ^ CRC_POLY;
			else c = c << 1;
		end
		return c;
	endfunction

endpackage

// [shared/udmab_link_if.sv]
`timescale 1ns/1ps
interface udmab_link_if;
	import udmab_pkg::*;

	logic              dmarq;
	logic              dmack;
	logic              stop;
	logic              hioe;
	logic              iordy_o;
	logic              iordy_oe;
	logic              iordy;
	logic [DATA_W-1:0] hd_d;
	logic              hd_d_oe;
	logic [DATA_W-1:0] hd_h;
	logic              hd_h_oe;
	logic [DATA_W-1:0] hd;

	// Host pull-up gives the released line a known level
	assign iordy = iordy_oe ? iordy_o : 1'b1;
	assign hd    = hd_d_oe ? hd_d : (hd_h_oe ? hd_h : {DATA_W{1'b1}});

	modport dev (
		input  dmack, stop, hioe, hd,
		output dmarq, iordy_o, iordy_oe, hd_d, hd_d_oe
	);
	modport host (
		input  dmarq, iordy, hd,
		output dmack, stop, hioe, hd_h, hd_h_oe
	);
endinterface

// [hw/udmab_fifo.sv]
`timescale 1ns/1ps
module udmab_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int LW    = 4
) (
	// System
	input  wire logic             clk_sys_i,
	input  wire logic             reset_n_i,
	// Fill side
	input  wire logic             s_valid_i,
	input  wire logic [WIDTH-1:0] s_data_i,
	output logic                  s_ready_o,
	// Drain side
	output logic                  m_valid_o,
	output logic      [WIDTH-1:0] m_data_o,
	input  wire logic             m_ready_i,
	// Fill level
	output logic         [LW-1:0] lvl_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic    [AW-1:0] wp;
	logic    [AW-1:0] rp;

	wire          push     = s_valid_i & s_ready_o;
	wire          pop      = (lvl_o != '0) & (~m_valid_o | m_ready_i);
	wire [LW-1:0] next_cnt = lvl_o + LW'(push) - LW'(pop);

	always_ff @(posedge clk_sys_i) begin
		if (push) mem[wp] <= s_data_i;
	end

	// Output stage is a register so the drain side sees clean flops
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lvl_o     <= '0;
			wp        <= '0;
			rp        <= '0;
			s_ready_o <= 1'b1;
			m_valid_o <= 1'b0;
			m_data_o  <= '0;
		end else begin
			lvl_o     <= next_cnt;
			s_ready_o <= next_cnt != LW'(DEPTH);
			if (push) wp <= wp + 1'b1;
			if (pop) begin
				m_data_o  <= mem[rp];
				rp        <= rp + 1'b1;
				m_valid_o <= 1'b1;
			end else if (m_ready_i) begin
				m_valid_o <= 1'b0;
			end
		end
	end
endmodule // udmab_fifo

// [hw/udmab_dev.sv]
`timescale 1ns/1ps
module udmab_dev
	import udmab_pkg::*;
(
	// System
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	// Configuration
	input  wire logic              ide_compatible_mode_i,
	input  wire logic [MODE_W-1:0] udma_mode_i,
	input  wire logic              dir_in_i,
	input  wire logic              burst_req_i,
	// Words to send to the host
	input  wire logic              tx_valid_i,
	input  wire logic [DATA_W-1:0] tx_data_i,
	output logic                   tx_ready_o,
	// Words received from the host
	output logic                   rx_valid_o,
	output logic      [DATA_W-1:0] rx_data_o,
	input  wire logic              rx_ready_i,
	// Status
	output logic                   burst_active_o,
	output logic      [DATA_W-1:0] crc_word_o,
	output logic                   crc_err_o,
	// Link
	udmab_link_if.dev              link
);
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_REQ   = 4'h1,
		ST_DI_FS = 4'h2,
		ST_DI_XF = 4'h3,
		ST_DI_SS = 4'h4,
		ST_DO_XF = 4'h5,
		ST_DO_RP = 4'h6,
		ST_END   = 4'h7
	} udmab_dev_st_t;

	localparam int SW = DATA_W + 3;

	udmab_dev_st_t     st;
	logic     [SW-1:0] sync1;
	logic     [SW-1:0] sync2;
	logic              hioe_p;
	logic              dmarq;
	logic              iordy_o;
	logic              iordy_oe;
	logic [DATA_W-1:0] hd_o;
	logic              hd_oe;
	logic              dir_in;
	logic              pend;
	logic  [TMR_W-1:0] tmr;
	logic [DATA_W-1:0] crc;
	logic              tx_m_valid;
	logic [DATA_W-1:0] tx_m_data;
	logic              tx_pop;
	logic              rx_push;
	logic [FIFO_LW-1:0] rx_lvl;

	wire              dmack_s = sync2[SW-1];
	wire              stop_s  = sync2[SW-2];
	wire              hioe_s  = sync2[SW-3];
	wire [DATA_W-1:0] hd_s    = sync2[DATA_W-1:0];

	wire [MODE_W-1:0] mode  = (udma_mode_i > MODE_MAX) ? MODE_MAX
		: udma_mode_i;
	wire  [TMR_W-1:0] c_gap = cyc_min((T2CYC_NS[mode] + 1) / 2);
	wire  [TMR_W-1:0] c_rp  = cyc_min(T_RP_NS[mode]);
	wire  [TMR_W-1:0] c_ss  = cyc_min(T_SS_NS);

	wire burst       = dmarq & dmack_s;
	wire strobe_edge = burst & (hioe_s ^ hioe_p);
	wire tmr_done    = tmr == '0;
	wire rx_room     = rx_lvl < RX_STOP_LVL;
	wire di_go       = hioe_s & ~stop_s & tx_m_valid;

	assign tx_pop  = (st == ST_DI_FS & di_go)
		| (st == ST_DI_XF & tmr_done & ~pend & di_go);
	assign rx_push = strobe_edge & ~dir_in
		& (st == ST_DO_XF | st == ST_DO_RP);

	assign link.dmarq    = dmarq;
	assign link.iordy_o  = iordy_o;
	assign link.iordy_oe = iordy_oe;
	assign link.hd_d     = hd_o;
	assign link.hd_d_oe  = hd_oe;

	udmab_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH),
		.LW    (FIFO_LW)
	) u_tx_fifo (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.s_valid_i (tx_valid_i),
		.s_data_i  (tx_data_i),
		.s_ready_o (tx_ready_o),
		.m_valid_o (tx_m_valid),
		.m_data_o  (tx_m_data),
		.m_ready_i (tx_pop),
		.lvl_o     ()
	);

	// Margin in the level check means a push never meets a full FIFO
	udmab_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH),
		.LW    (FIFO_LW)
	) u_rx_fifo (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.s_valid_i (rx_push),
		.s_data_i  (hd_s),
		.s_ready_o (),
		.m_valid_o (rx_valid_o),
		.m_data_o  (rx_data_o),
		.m_ready_i (rx_ready_i),
		.lvl_o     (rx_lvl)
	);

	// Data rides the same two stages as the strobe, so they stay aligned
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1  <= '0;
			sync2  <= '0;
			hioe_p <= 1'b0;
		end else begin
			sync1  <= {link.dmack, link.stop, link.hioe, link.hd};
			sync2  <= sync1;
			hioe_p <= hioe_s;
		end
	end

	// Outside IDE-compatible mode the pin keeps its ordinary driven role
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			iordy_oe       <= 1'b0;
			burst_active_o <= 1'b0;
		end else begin
			iordy_oe       <= ~ide_compatible_mode_i
				| (dmack_s & st != ST_IDLE);
			burst_active_o <= burst;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st         <= ST_IDLE;
			dmarq      <= 1'b0;
			iordy_o    <= 1'b1;
			hd_o       <= '0;
			hd_oe      <= 1'b0;
			dir_in     <= 1'b0;
			pend       <= 1'b0;
			tmr        <= '0;
			crc        <= CRC_SEED;
			crc_word_o <= '0;
			crc_err_o  <= 1'b0;
		end else begin
			if (rx_push) crc <= crc_next(crc, hd_s);
			unique case (st)
			ST_IDLE: begin
				if (burst_req_i & (~dir_in_i | tx_m_valid)) begin
					dmarq  <= 1'b1;
					dir_in <= dir_in_i;
					crc    <= CRC_SEED;
					st     <= ST_REQ;
				end
			end
			ST_REQ: begin
				if (dmack_s & (dir_in | hioe_s)) begin
					if (dir_in) begin
						st <= ST_DI_FS;
					end else begin
						iordy_o <= rx_room;
						st      <= ST_DO_XF;
					end
				end
			end
			ST_DI_FS: begin
				if (tx_pop) begin
					hd_o  <= tx_m_data;
					hd_oe <= 1'b1;
					pend  <= 1'b1;
					tmr   <= c_gap;
					st    <= ST_DI_XF;
				end
			end
			ST_DI_XF: begin
				if (stop_s) begin
					dmarq <= 1'b0;
					hd_oe <= 1'b0;
					pend  <= 1'b0;
					st    <= ST_END;
				end else if (!tmr_done) begin
					tmr <= tmr - 1'b1;
				end else if (pend) begin
					if (hioe_s) begin
						iordy_o <= ~iordy_o;
						crc     <= crc_next(crc, hd_o);
						pend    <= 1'b0;
						tmr     <= c_gap;
					end
				end else if (tx_pop) begin
					hd_o <= tx_m_data;
					pend <= 1'b1;
					tmr  <= c_gap;
				end else if (!burst_req_i) begin
					tmr <= c_ss;
					st  <= ST_DI_SS;
				end
			end
			ST_DI_SS: begin
				if (stop_s | tmr_done) begin
					dmarq <= 1'b0;
					hd_oe <= 1'b0;
					st    <= ST_END;
				end else begin
					tmr <= tmr - 1'b1;
				end
			end
			ST_DO_XF: begin
				if (stop_s) begin
					dmarq <= 1'b0;
					st    <= ST_END;
				end else if (!burst_req_i) begin
					iordy_o <= 1'b0;
					tmr     <= c_rp;
					st      <= ST_DO_RP;
				end else begin
					iordy_o <= rx_room;
				end
			end
			ST_DO_RP: begin
				if (stop_s | tmr_done) begin
					dmarq <= 1'b0;
					st    <= ST_END;
				end else begin
					tmr <= tmr - 1'b1;
				end
			end
			ST_END: begin
				if (!dmack_s) begin
					crc_word_o <= hd_s;
					crc_err_o  <= hd_s != crc;
					iordy_o    <= 1'b1;
					st         <= ST_IDLE;
				end
			end
			endcase
		end
	end
endmodule // udmab_dev

// [hw/udmab_host.sv]
`timescale 1ns/1ps
module udmab_host
	import udmab_pkg::*;
(
	// System
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	// Configuration and control
	input  wire logic [MODE_W-1:0] udma_mode_i,
	input  wire logic              enable_i,
	input  wire logic              dir_in_i,
	input  wire logic              pause_i,
	input  wire logic              stop_req_i,
	// Words to send to the device
	input  wire logic              tx_valid_i,
	input  wire logic [DATA_W-1:0] tx_data_i,
	output logic                   tx_ready_o,
	// Words received from the device
	output logic                   rx_valid_o,
	output logic      [DATA_W-1:0] rx_data_o,
	// Status
	output logic                   busy_o,
	// Link
	udmab_link_if.host             link
);
	typedef enum logic [3:0] {
		H_IDLE   = 4'h0,
		H_ENV    = 4'h1,
		H_IN     = 4'h2,
		H_IN_RP  = 4'h3,
		H_OUT    = 4'h4,
		H_OUT_SS = 4'h5,
		H_STOP   = 4'h6,
		H_CRC    = 4'h7,
		H_ACK    = 4'h8,
		H_HOLD   = 4'h9
	} udmab_host_st_t;

	localparam int SW = DATA_W + 2;

	udmab_host_st_t    st;
	logic     [SW-1:0] sync1;
	logic     [SW-1:0] sync2;
	logic              iordy_p;
	logic              dmack;
	logic              stop;
	logic              hioe;
	logic [DATA_W-1:0] hd_o;
	logic              hd_oe;
	logic              dir_in;
	logic              pend;
	logic  [TMR_W-1:0] tmr;
	logic [DATA_W-1:0] crc;

	wire              dmarq_s = sync2[SW-1];
	wire              iordy_s = sync2[SW-2];
	wire [DATA_W-1:0] hd_s    = sync2[DATA_W-1:0];

	wire [MODE_W-1:0] mode  = (udma_mode_i > MODE_MAX) ? MODE_MAX
		: udma_mode_i;
	wire  [TMR_W-1:0] c_gap = cyc_min((T2CYC_NS[mode] + 1) / 2);
	wire  [TMR_W-1:0] c_rp  = cyc_min(T_RP_NS[mode]);
	wire  [TMR_W-1:0] c_ss  = cyc_min(T_SS_NS);
	wire  [TMR_W-1:0] c_env = cyc_min(T_ENV_NS);
	wire  [TMR_W-1:0] c_ack = cyc_min(T_ACK_NS);
	wire  [TMR_W-1:0] c_crc = cyc_min(T_MLI_NS > T_ZAH_NS ? T_MLI_NS
		: T_ZAH_NS);

	wire tmr_done = tmr == '0;
	wire in_phase = st == H_IN | st == H_IN_RP | st == H_STOP;
	wire in_edge  = dir_in & in_phase & dmarq_s & dmack
		& (iordy_s ^ iordy_p);

	assign link.dmack   = dmack;
	assign link.stop    = stop;
	assign link.hioe    = hioe;
	assign link.hd_h    = hd_o;
	assign link.hd_h_oe = hd_oe;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1   <= '0;
			sync2   <= '0;
			iordy_p <= 1'b1;
		end else begin
			sync1   <= {link.dmarq, link.iordy, link.hd};
			sync2   <= sync1;
			iordy_p <= iordy_s;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_valid_o <= 1'b0;
			rx_data_o  <= '0;
			busy_o     <= 1'b0;
		end else begin
			rx_valid_o <= in_edge;
			rx_data_o  <= hd_s;
			busy_o     <= st != H_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st         <= H_IDLE;
			dmack      <= 1'b0;
			stop       <= 1'b0;
			hioe       <= 1'b0;
			hd_o       <= '0;
			hd_oe      <= 1'b0;
			dir_in     <= 1'b0;
			pend       <= 1'b0;
			tmr        <= '0;
			crc        <= CRC_SEED;
			tx_ready_o <= 1'b0;
		end else begin
			tx_ready_o <= 1'b0;
			if (in_edge) crc <= crc_next(crc, hd_s);
			unique case (st)
			H_IDLE: begin
				if (enable_i & dmarq_s) begin
					dmack  <= 1'b1;
					dir_in <= dir_in_i;
					crc    <= CRC_SEED;
					tmr    <= c_env;
					st     <= H_ENV;
				end
			end
			H_ENV: begin
				if (!tmr_done) begin
					tmr <= tmr - 1'b1;
				end else begin
					stop  <= 1'b0;
					hioe  <= 1'b1;
					hd_oe <= ~dir_in;
					pend  <= 1'b0;
					tmr   <= '0;
					st    <= dir_in ? H_IN : H_OUT;
				end
			end
			H_IN: begin
				if (!dmarq_s) begin
					tmr <= c_crc;
					st  <= H_CRC;
				end else if (stop_req_i) begin
					hioe <= 1'b0;
					tmr  <= c_rp;
					st   <= H_IN_RP;
				end else begin
					hioe <= ~pause_i;
				end
			end
			H_IN_RP: begin
				if (!dmarq_s) begin
					tmr <= c_crc;
					st  <= H_CRC;
				end else if (!tmr_done) begin
					tmr <= tmr - 1'b1;
				end else begin
					stop <= 1'b1;
					st   <= H_STOP;
				end
			end
			H_OUT: begin
				if (!dmarq_s) begin
					stop <= 1'b1;
					pend <= 1'b0;
					tmr  <= c_crc;
					st   <= H_CRC;
				end else if (!tmr_done) begin
					tmr <= tmr - 1'b1;
				end else if (pend) begin
					if (iordy_s) begin
						hioe <= ~hioe;
						crc  <= crc_next(crc, hd_o);
						pend <= 1'b0;
						tmr  <= c_gap;
					end
				end else if (stop_req_i) begin
					tmr <= c_ss;
					st  <= H_OUT_SS;
				end else if (tx_valid_i) begin
					hd_o       <= tx_data_i;
					tx_ready_o <= 1'b1;
					pend       <= 1'b1;
					tmr        <= c_gap;
				end
			end
			H_OUT_SS: begin
				if (!tmr_done) begin
					tmr <= tmr - 1'b1;
				end else begin
					stop <= 1'b1;
					st   <= H_STOP;
				end
			end
			H_STOP: begin
				if (!dmarq_s) begin
					tmr <= c_crc;
					st  <= H_CRC;
				end
			end
			H_CRC: begin
				if (!tmr_done) begin
					tmr <= tmr - 1'b1;
				end else begin
					hd_o  <= crc;
					hd_oe <= 1'b1;
					tmr   <= c_ack;
					st    <= H_ACK;
				end
			end
			H_ACK: begin
				if (!tmr_done) begin
					tmr <= tmr - 1'b1;
				end else begin
					dmack <= 1'b0;
					tmr   <= c_ack;
					st    <= H_HOLD;
				end
			end
			H_HOLD: begin
				if (!tmr_done) begin
					tmr <= tmr - 1'b1;
				end else begin
					hd_oe <= 1'b0;
					stop  <= 1'b0;
					hioe  <= 1'b0;
					st    <= H_IDLE;
				end
			end
			endcase
		end
	end
endmodule // udmab_host

// [bench/udmab_monitor.sv]
`timescale 1ns/1ps
module udmab_monitor
	import udmab_pkg::*;
(
	// System
	input wire logic              clk_sys_i,
	input wire logic              reset_n_i,
	// Link
	input wire logic              dmarq,
	input wire logic              dmack,
	input wire logic              stop,
	input wire logic              hioe,
	input wire logic              iordy_o,
	input wire logic              iordy_oe,
	input wire logic              iordy,
	input wire logic [DATA_W-1:0] hd_d,
	input wire logic              hd_d_oe,
	input wire logic [DATA_W-1:0] hd_h,
	input wire logic              hd_h_oe,
	input wire logic [DATA_W-1:0] hd
);
	logic       strobe_last;
	logic       ready_last;
	logic [7:0] strobe_age;
	logic [7:0] ready_age;
	wire  [7:0] next_strobe_age;
	wire  [7:0] next_ready_age;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	// Ages saturate so a long idle never wraps into a false short gap
	assign next_strobe_age = (iordy_o != strobe_last) ? 8'h00 :
		strobe_age + {7'h00, strobe_age != 8'hFF};
	assign next_ready_age = (hioe != ready_last) ? 8'h00 :
		ready_age + {7'h00, ready_age != 8'hFF};

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strobe_last <= 1'b1;
			ready_last  <= 1'b0;
			strobe_age  <= 8'hFF;
			ready_age   <= 8'hFF;
		end else begin
			strobe_last <= iordy_o;
			ready_last  <= hioe;
			strobe_age  <= next_strobe_age;
			ready_age   <= next_ready_age;
		end
	end

	property p_bus_fight;
		!(hd_d_oe && hd_h_oe);
	endproperty
	a_bus_fight: assert property (p_bus_fight)
		else $error("both ends drive the data bus");
	property p_turnaround;
		$fell(hd_d_oe) |-> !hd_h_oe ##1 !hd_h_oe;
	endproperty
	a_turnaround: assert property (p_turnaround)
		else $error("host drove the bus too soon after release");
	property p_envelope;
		$rose(dmack) |-> (!hioe)[*2] ##[1:4] (hioe && !stop);
	endproperty
	a_envelope: assert property (p_envelope)
		else $error("ready not driven inside the envelope");
	property p_burst_only;
		hd_d_oe |-> dmarq && dmack;
	endproperty
	a_burst_only: assert property (p_burst_only)
		else $error("device drives data outside a burst");
	property p_crc_hold;
		$fell(dmack) |-> $past(hd_h_oe) && hd_h_oe && $stable(hd_h)
			##1 (hd_h_oe && $stable(hd_h));
	endproperty
	a_crc_hold: assert property (p_crc_hold)
		else $error("crc word not stable around ack negation");
	property p_ack_hold;
		$changed(dmack) |-> $stable(stop) ##1 $stable(stop);
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("stop moved too close to an ack change");
	property p_sender_end;
		$fell(dmarq) && !stop |-> strobe_age >= 8'h04;
	endproperty
	a_sender_end: assert property (p_sender_end)
		else $error("request dropped too soon after last strobe");
	property p_final_strobe;
		hd_d_oe && !hioe && ready_age >= 8'h0A |-> $stable(iordy_o);
	endproperty
	a_final_strobe: assert property (p_final_strobe)
		else $error("strobe edge long after ready dropped");
	property p_pause_wait;
		$rose(stop) && hd_d_oe |-> !hioe && ready_age >= 8'h08;
	endproperty
	a_pause_wait: assert property (p_pause_wait)
		else $error("stop raised before ready-to-pause time");
	property p_first_strobe;
		$rose(hd_d_oe) |-> ##[1:20] $fell(iordy_o);
	endproperty
	a_first_strobe: assert property (p_first_strobe)
		else $error("first strobe late");
endmodule // udmab_monitor

// [bench/udmab_test.sv]
`timescale 1ns/1ps
module udmab_test;
	import udmab_pkg::*;

	logic              clk_sys_i;
	logic              reset_n_i;
	logic              ide_mode;
	logic [MODE_W-1:0] mode;
	logic              dir_in;
	logic              burst_req;
	logic              enable;
	logic              pause;
	logic              pause_en;
	logic              stop_req;
	logic              stall;
	logic              d_tx_valid;
	logic [DATA_W-1:0] d_tx_data;
	logic              d_tx_ready;
	logic              d_rx_valid;
	logic [DATA_W-1:0] d_rx_data;
	logic              d_rx_ready;
	logic              active;
	logic [DATA_W-1:0] crc_word;
	logic              crc_err;
	logic              h_tx_valid;
	logic [DATA_W-1:0] h_tx_data;
	logic              h_tx_ready;
	logic              h_rx_valid;
	logic [DATA_W-1:0] h_rx_data;
	logic              busy;
	int                n_errors;
	int                samples_checked;
	int                seed;
	logic [DATA_W-1:0] sent_q[$];
	logic [DATA_W-1:0] got_q[$];

	udmab_link_if link ();

	udmab_dev u_udmab_dev (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.ide_compatible_mode_i(ide_mode), .udma_mode_i(mode),
		.dir_in_i(dir_in), .burst_req_i(burst_req),
		.tx_valid_i(d_tx_valid), .tx_data_i(d_tx_data),
		.tx_ready_o(d_tx_ready), .rx_valid_o(d_rx_valid),
		.rx_data_o(d_rx_data), .rx_ready_i(d_rx_ready),
		.burst_active_o(active), .crc_word_o(crc_word),
		.crc_err_o(crc_err), .link(link)
	);
	udmab_host u_udmab_host (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.udma_mode_i(mode), .enable_i(enable), .dir_in_i(dir_in),
		.pause_i(pause), .stop_req_i(stop_req), .tx_valid_i(h_tx_valid),
		.tx_data_i(h_tx_data), .tx_ready_o(h_tx_ready),
		.rx_valid_o(h_rx_valid), .rx_data_o(h_rx_data),
		.busy_o(busy), .link(link)
	);
	udmab_monitor u_udmab_monitor (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.dmarq(link.dmarq), .dmack(link.dmack), .stop(link.stop),
		.hioe(link.hioe), .iordy_o(link.iordy_o), .iordy_oe(link.iordy_oe),
		.iordy(link.iordy), .hd_d(link.hd_d), .hd_d_oe(link.hd_d_oe),
		.hd_h(link.hd_h), .hd_h_oe(link.hd_h_oe), .hd(link.hd)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// Random receive stalls and pauses push the ready lines around
	always @(posedge clk_sys_i) begin
		d_rx_ready <= !stall || ($random(seed) & 3) == 0;
		pause      <= pause_en && ($random(seed) & 1) == 1;
		if (h_rx_valid === 1'b1)
			got_q.push_back(h_rx_data);
		if (d_rx_valid === 1'b1 && d_rx_ready === 1'b1)
			got_q.push_back(d_rx_data);
	end

	function automatic logic [DATA_W-1:0] crc_step(
		input logic [DATA_W-1:0] c, input logic [DATA_W-1:0] w);
		for (int i = DATA_W - 1; i >= 0; i--)
			c = {c[DATA_W-2:0], 1'b0} ^ ((c[DATA_W-1] ^ w[i]) ? CRC_POLY : '0);
		return c;
	endfunction

	task automatic check_word(input string what,
		input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp,
		input logic got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Valid stays up between words, so it is never set twice in a step
	task automatic push(input logic [DATA_W-1:0] w);
		if (dir_in) begin
			d_tx_valid <= 1'b1;
			d_tx_data  <= w;
		end else begin
			h_tx_valid <= 1'b1;
			h_tx_data  <= w;
		end
		for (int k = 0; k < 300; k++) begin
			@(posedge clk_sys_i);
			if ((dir_in ? d_tx_ready : h_tx_ready) === 1'b1)
				break;
		end
	endtask

	task automatic run_burst(input int t);
		int                n;
		int                k;
		logic [DATA_W-1:0] crc;
		logic              host_end;
		n = (t[0] && t[3]) ? 9 : 1 + ($random(seed) & 7);
		host_end = 1'($random(seed));
		mode     <= MODE_W'(t / 2);
		dir_in   <= t[0];
		ide_mode <= 1'($random(seed));
		stall    <= 1'($random(seed));
		enable   <= 1'b1;
		sent_q.delete();
		got_q.delete();
		crc = CRC_SEED;
		for (k = 0; k < n; k++) begin
			sent_q.push_back(DATA_W'($random(seed)));
			crc = crc_step(crc, sent_q[k]);
		end
		@(posedge clk_sys_i);
		if (t[0]) begin
			foreach (sent_q[i]) push(sent_q[i]);
			d_tx_valid <= 1'b0;
			repeat (2) @(posedge clk_sys_i);
			check_bit("dev tx ready", n < 9, d_tx_ready);
			burst_req <= 1'b1;
		end else begin
			burst_req <= 1'b1;
			foreach (sent_q[i]) push(sent_q[i]);
			h_tx_valid <= 1'b0;
		end
		for (k = 0; k < 4000 && got_q.size() < n; k++) begin
			pause_en <= t[0] && got_q.size() > 0;
			@(posedge clk_sys_i);
		end
		pause_en <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		if (host_end) begin
			stop_req <= 1'b1;
			enable   <= 1'b0;
		end else
			burst_req <= 1'b0;
		@(posedge clk_sys_i);
		// Request drops once the device lets go, so no new burst starts
		for (k = 0; k < 600; k++) begin
			if (busy === 1'b0 && link.dmack === 1'b0)
				break;
			if (link.dmarq === 1'b0)
				burst_req <= 1'b0;
			@(posedge clk_sys_i);
		end
		check_bit("host idle", 1'b0, busy);
		burst_req <= 1'b0;
		stop_req  <= 1'b0;
		repeat (40) @(posedge clk_sys_i);
		check_word("word count", DATA_W'(n), DATA_W'(got_q.size()));
		foreach (got_q[i]) check_word("word", sent_q[i], got_q[i]);
		check_word("crc word", crc, crc_word);
		check_bit("crc error", 1'b0, crc_err);
		check_bit("iordy drive", !ide_mode, link.iordy_oe);
		check_bit("burst active", 1'b0, active);
		$display("test %0d mode %0d dir %0d host end %0d words %0d done",
			t, mode, t[0], host_end, n);
	endtask

	// Bound well above fourteen bursts at the slowest mode
	initial begin
		#400_000;
		n_errors++;
		$display("unexpected watchdog expected finish seen timeout");
		conclude();
	end

	initial begin
		seed = 89172;
		n_errors = 0;
		samples_checked = 0;
		reset_n_i = 1'b0;
		{ide_mode, dir_in, burst_req, enable, pause, pause_en} = '0;
		{stop_req, stall, d_tx_valid, h_tx_valid} = '0;
		mode = '0;
		d_tx_data = '0;
		h_tx_data = '0;
		d_rx_ready = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		for (int t = 0; t < 14; t++) begin
			if (t == 7) begin
				reset_n_i <= 1'b0;
				@(posedge clk_sys_i);
				check_bit("dmarq in reset", 1'b0, link.dmarq);
				check_bit("dmack in reset", 1'b0, link.dmack);
				reset_n_i <= 1'b1;
			end
			run_burst(t);
		end
		conclude();
	end
endmodule // udmab_test
